/* File: hw/pid_pkg.sv */
// Purpose: shared constants, register map and carriers for the pid setpoint controller
// Assumes: 200 MHz pclk, 32-bit APB data
// Notes: setpoints in 0.01 Hz counts, percentages scaled to 400.00 Hz full scale
package pid_pkg;
	localparam int CLK_HZ = 32'h0beb_c200;
	localparam int MS_PER_S = 32'h0000_03e8;
	localparam int TICK_MS = 32'h0000_0007;
	localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
	// integral and filter times in 0.1 s steps, derivative in 0.01 s steps, as ms
	localparam int TI_MS_PER_STEP = 32'h0000_0064;
	localparam int TD_MS_PER_STEP = 32'h0000_000a;
	localparam int GAIN_DEN = 32'h0000_0064;
	localparam int KP_DEN = 32'h0000_000a;
	localparam int PCT_COUNTS = 32'h0000_0190;

	localparam logic [15:0] SP_MAX_FREQ = 16'h9c40;
	localparam logic [15:0] SP_MAX_PCT = 16'h2710;
	localparam logic [11:0] ADC_FS = 12'h0fff;
	localparam logic [11:0] ADC_4MA = 12'h0333;
	localparam logic [11:0] ADC_SPAN_CUR = 12'h0ccc;

	localparam logic [3:0] MODE_PID = 4'h2;
	localparam logic [7:0] FUNC_PID = 8'h09;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SP0 = 8'h04;
	localparam logic [7:0] OFS_GAIN = 8'h18;
	localparam logic [7:0] OFS_KP = 8'h1c;
	localparam logic [7:0] OFS_TI = 8'h20;
	localparam logic [7:0] OFS_TD = 8'h24;
	localparam logic [7:0] OFS_BIAS = 8'h28;
	localparam logic [7:0] OFS_UB = 8'h2c;
	localparam logic [7:0] OFS_FILT = 8'h30;
	localparam logic [7:0] OFS_OUT = 8'h34;
	localparam logic [7:0] OFS_ACC = 8'h38;

	localparam logic [15:0] SP_RST [5] = '{16'h1770, 16'h0000, 16'h0000, 16'h0000, 16'h0258};
	localparam logic [15:0] GAIN_RST = 16'h0064;
	localparam logic [15:0] KP_RST = 16'h000a;
	localparam logic [15:0] TI_RST = 16'h0064;
	localparam logic [15:0] TD_RST = 16'h0000;
	localparam logic [15:0] BIAS_RST = 16'h0000;
	localparam logic [15:0] UB_RST = 16'h0064;
	localparam logic [15:0] FILT_RST = 16'h0000;
	localparam logic [14:0] CTRL_RST = 15'h0000;

	typedef struct packed {
		logic display_mode;
		logic fb_current;
		logic ref_stored;
		logic [7:0] pid_function_select;
		logic [3:0] control_mode_select;
	} cfg_s;

	typedef struct packed {
		logic jog;
		logic step2;
		logic step1;
		logic integral_reset;
		logic pid_cancel;
	} contact_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INT = 2'b01,
		ST_SUM = 2'b11,
		ST_FILT = 2'b10
	} calc_e;
endpackage : pid_pkg

/* File: hw/tick_gen.sv */
// Purpose: one-cycle enable pulse every sample period
// Assumes: single pclk domain
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/1ps
module tick_gen #(
	parameter int PERIOD = pid_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	logic [31:0] count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (count == 32'(PERIOD - 1)) begin
			count <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule : tick_gen

/* File: hw/serial_div.sv */
// Purpose: unsigned restoring divider, one quotient bit per cycle
// Assumes: divisor nonzero when started
// Notes: 32 cycles per result; trades speed for one shared small datapath
`timescale 1ns/1ps
module serial_div (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [31:0] dividend,
	input wire logic [31:0] divisor,
	output logic done,
	output logic [31:0] quotient
);
	logic [31:0] rem;
	logic [31:0] den;
	logic [5:0] bits;
	logic busy;
	logic [32:0] trial;

	assign trial = {rem[31:0], quotient[31]} - {1'b0, den};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem <= 32'h0000_0000;
			den <= 32'h0000_0000;
			quotient <= 32'h0000_0000;
			bits <= 6'h00;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				rem <= 32'h0000_0000;
				den <= divisor;
				quotient <= dividend;
				bits <= 6'h20;
				busy <= 1'b1;
			end else if (busy) begin
				if (!trial[32]) begin
					rem <= trial[31:0];
					quotient <= {quotient[30:0], 1'b1};
				end else begin
					rem <= {rem[30:0], quotient[31]};
					quotient <= {quotient[30:0], 1'b0};
				end
				bits <= bits - 6'h01;
				if (bits == 6'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : serial_div

/* File: hw/pid_setpoint_controller.sv */
// Purpose: sampled PID controller producing a speed reference
// Assumes: contact inputs already decoded to their assigned functions, ADC codes synchronous
// Notes: integral and filter divides run once per sample tick through one shared divider; P and D terms use their own divides
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pid_setpoint_controller #(
	parameter int TICK_PERIOD = pid_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pid_pkg::contact_s contacts,
	input wire logic [11:0] analog_ref,
	input wire logic [11:0] fb_voltage,
	input wire logic [11:0] fb_current,
	output logic [15:0] ref_out,
	output logic aes_enable,
	output logic pid_active
);
	pid_pkg::cfg_s cfg;
	logic [15:0] sp [5];
	logic [15:0] gain, kp, ti, td, bias, ub, filt;
	logic [15:0] sp_sel, sp_max, analog_word, fb_word;
	logic signed [31:0] dev, dev_prev, p_term, d_term, acc, sum, y, lim, next_acc;
	logic pid_on, tick, wr, rd_setup, div_start, div_done, neg, skip_div;
	logic [31:0] div_num, div_den, quot;
	logic [7:0] addr;
	pid_pkg::calc_e st;

	tick_gen #(.PERIOD(TICK_PERIOD)) u_tick (.pclk(pclk), .presetn(presetn), .tick(tick));
	serial_div u_div (.pclk(pclk), .presetn(presetn), .start(div_start), .dividend(div_num),
		.divisor(div_den), .done(div_done), .quotient(quot));

	// zero wait states; read data is captured in the setup cycle
	assign addr = paddr[7:0];
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pslverr = psel && penable && (paddr[31:8] != 24'h00_0000 || addr[1:0] != 2'b00
		|| addr > pid_pkg::OFS_ACC);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= pid_pkg::CTRL_RST;
		end else if (wr && addr == pid_pkg::OFS_CTRL) begin
			cfg <= pwdata[14:0];
		end
	end

	assign sp_max = cfg.display_mode ? pid_pkg::SP_MAX_PCT : pid_pkg::SP_MAX_FREQ;

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sp
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sp[gi] <= pid_pkg::SP_RST[gi];
				end else if (wr && addr == pid_pkg::OFS_SP0 + 8'(4 * gi)) begin
					sp[gi] <= (pwdata[15:0] > sp_max) ? sp_max : pwdata[15:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain <= pid_pkg::GAIN_RST;
			kp <= pid_pkg::KP_RST;
			ti <= pid_pkg::TI_RST;
			td <= pid_pkg::TD_RST;
			bias <= pid_pkg::BIAS_RST;
			ub <= pid_pkg::UB_RST;
			filt <= pid_pkg::FILT_RST;
		end else if (wr) begin
			case (addr)
				pid_pkg::OFS_GAIN: gain <= pwdata[15:0];
				pid_pkg::OFS_KP: kp <= pwdata[15:0];
				pid_pkg::OFS_TI: ti <= pwdata[15:0];
				pid_pkg::OFS_TD: td <= pwdata[15:0];
				pid_pkg::OFS_BIAS: bias <= pwdata[15:0];
				pid_pkg::OFS_UB: ub <= pwdata[15:0];
				pid_pkg::OFS_FILT: filt <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			case (addr)
				pid_pkg::OFS_CTRL: prdata <= {17'h0_0000, cfg};
				pid_pkg::OFS_GAIN: prdata <= {16'h0000, gain};
				pid_pkg::OFS_KP: prdata <= {16'h0000, kp};
				pid_pkg::OFS_TI: prdata <= {16'h0000, ti};
				pid_pkg::OFS_TD: prdata <= {16'h0000, td};
				pid_pkg::OFS_BIAS: prdata <= {16'h0000, bias};
				pid_pkg::OFS_UB: prdata <= {16'h0000, ub};
				pid_pkg::OFS_FILT: prdata <= {16'h0000, filt};
				pid_pkg::OFS_OUT: prdata <= {14'h0000, pid_on, aes_enable, ref_out};
				pid_pkg::OFS_ACC: prdata <= acc;
				default: prdata <= (addr >= pid_pkg::OFS_SP0 && addr < pid_pkg::OFS_GAIN) ?
					{16'h0000, sp[3'((addr - pid_pkg::OFS_SP0) >> 2)]} : 32'h0000_0000;
			endcase
		end
	end

	// ADC codes scaled to 0.01 Hz; the current input drops its 4 mA live zero
	assign analog_word = 16'((32'(analog_ref) * 32'(pid_pkg::SP_MAX_FREQ)) / 32'(pid_pkg::ADC_FS));
	always_comb begin
		if (!cfg.fb_current) begin
			fb_word = 16'((32'(fb_voltage) * 32'(pid_pkg::SP_MAX_FREQ)) / 32'(pid_pkg::ADC_FS));
		end else if (fb_current <= pid_pkg::ADC_4MA) begin
			fb_word = 16'h0000;
		end else begin
			fb_word = 16'((32'(fb_current - pid_pkg::ADC_4MA) * 32'(pid_pkg::SP_MAX_FREQ))
				/ 32'(pid_pkg::ADC_SPAN_CUR));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_sel <= 16'h0000;
		end else if (contacts.jog) begin
			sp_sel <= sp[4];
		end else begin
			case ({contacts.step2, contacts.step1})
				2'b00: sp_sel <= cfg.ref_stored ? sp[0] : analog_word;
				2'b01: sp_sel <= sp[1];
				2'b10: sp_sel <= sp[2];
				2'b11: sp_sel <= sp[3];
				default: sp_sel <= sp[0];
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aes_enable <= 1'b0;
			pid_active <= 1'b0;
		end else begin
			aes_enable <= cfg.control_mode_select == pid_pkg::MODE_PID;
			pid_active <= pid_on;
		end
	end
	assign pid_on = cfg.control_mode_select == pid_pkg::MODE_PID
		&& cfg.pid_function_select == pid_pkg::FUNC_PID;

	assign dev = 32'(sp_sel) - 32'((32'(fb_word) * 32'(gain)) / pid_pkg::GAIN_DEN);
	assign lim = 32'(ub) * pid_pkg::PCT_COUNTS;

	// divider runs on magnitudes; sign is restored when the quotient is used
	always_comb begin
		div_start = 1'b0;
		div_num = 32'h0000_0000;
		div_den = 32'h0000_0001;
		if (st == pid_pkg::ST_IDLE) begin
			div_num = 32'(dev < 0 ? -dev : dev) * pid_pkg::TICK_MS;
			div_den = 32'(ti) * pid_pkg::TI_MS_PER_STEP;
			div_start = tick && pid_on && ti != 16'h0000;
		end else if (st == pid_pkg::ST_SUM) begin
			div_num = 32'(sum - y < 0 ? y - sum : sum - y) * pid_pkg::TICK_MS;
			div_den = 32'(filt) * pid_pkg::TI_MS_PER_STEP;
			div_start = filt != 16'h0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= pid_pkg::ST_IDLE;
			neg <= 1'b0;
			skip_div <= 1'b0;
		end else begin
			case (st)
				// skip decided when a divide would start, so a later write cannot stall it
				pid_pkg::ST_IDLE: if (tick && pid_on) begin
					st <= pid_pkg::ST_INT;
					neg <= dev < 0;
					skip_div <= ti == 16'h0000;
				end
				pid_pkg::ST_INT: if (div_done || skip_div) st <= pid_pkg::ST_SUM;
				pid_pkg::ST_SUM: begin
					st <= pid_pkg::ST_FILT;
					neg <= sum < y;
					skip_div <= filt == 16'h0000;
				end
				pid_pkg::ST_FILT: if (div_done || skip_div) st <= pid_pkg::ST_IDLE;
				default: st <= pid_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_term <= 32'h0000_0000;
			d_term <= 32'h0000_0000;
			dev_prev <= 32'h0000_0000;
		end else if (st == pid_pkg::ST_IDLE && tick && pid_on) begin
			p_term <= (dev * $signed(32'(kp))) / pid_pkg::KP_DEN;
			d_term <= ((dev - dev_prev) * $signed(32'(td)) * pid_pkg::TD_MS_PER_STEP)
				/ pid_pkg::TICK_MS;
			dev_prev <= dev;
		end
	end

	always_comb begin
		next_acc = acc;
		if (st == pid_pkg::ST_INT && div_done) begin
			next_acc = neg ? acc - quot : acc + quot;
		end
		if (next_acc > lim) begin
			next_acc = lim;
		end else if (next_acc < -lim) begin
			next_acc = -lim;
		end
		if (contacts.integral_reset || !pid_on) begin
			next_acc = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= 32'h0000_0000;
		end else if (contacts.integral_reset || !pid_on) begin
			acc <= 32'h0000_0000;
		end else begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum <= 32'h0000_0000;
			y <= 32'h0000_0000;
		end else begin
			if (st == pid_pkg::ST_INT && (div_done || skip_div)) begin
				sum <= p_term + next_acc + d_term + 32'(bias) * pid_pkg::PCT_COUNTS;
			end
			if (!pid_on) begin
				y <= 32'h0000_0000;
			end else if (st == pid_pkg::ST_FILT && skip_div) begin
				y <= sum;
			end else if (st == pid_pkg::ST_FILT && div_done) begin
				y <= neg ? y - quot : y + quot;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_out <= 16'h0000;
		end else if (!pid_on || contacts.pid_cancel) begin
			ref_out <= sp_sel;
		end else if (y < 0) begin
			ref_out <= 16'h0000;
		end else if (y > 32'(sp_max)) begin
			ref_out <= sp_max;
		end else begin
			ref_out <= y[15:0];
		end
	end

	a_pid_bypass: assert property (@(posedge pclk) disable iff (!presetn)
		(!pid_on || contacts.pid_cancel) |=> ref_out == $past(sp_sel)) else $error("bypass lost");
	a_aes_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.control_mode_select == pid_pkg::MODE_PID) |=> aes_enable) else $error("aes off");
	a_jog_select: assert property (@(posedge pclk) disable iff (!presetn)
		contacts.jog |=> sp_sel == $past(sp[4])) else $error("jog setpoint wrong");
	a_analog_ref: assert property (@(posedge pclk) disable iff (!presetn)
		(!contacts.jog && !contacts.step1 && !contacts.step2 && !cfg.ref_stored)
		|=> sp_sel == $past(analog_word)) else $error("analog ref not used");
	a_int_reset: assert property (@(posedge pclk) disable iff (!presetn)
		contacts.integral_reset |=> acc == 32'h0000_0000) else $error("integral not cleared");
	a_int_clamp: assert property (@(posedge pclk) disable iff (!presetn)
		##1 (acc <= $past(lim) && acc >= -$past(lim))) else $error("integral over bound");
	a_tick_start: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && pid_on && st == pid_pkg::ST_IDLE) |=> st == pid_pkg::ST_INT) else $error("no calc");
	a_sum_terms: assert property (@(posedge pclk) disable iff (!presetn)
		(st == pid_pkg::ST_SUM) |-> sum == $past(p_term) + $past(next_acc) + $past(d_term)
		+ 32'($past(bias)) * pid_pkg::PCT_COUNTS) else $error("sum wrong");
	a_filt_bypass: assert property (@(posedge pclk) disable iff (!presetn)
		(pid_on && st == pid_pkg::ST_FILT && skip_div) |=> y == $past(sum))
		else $error("unfiltered output wrong");
	a_sp_range: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && addr == pid_pkg::OFS_SP0) |=> sp[0] <= $past(sp_max)) else $error("setpoint range");
	c_full_calc: cover property (@(posedge pclk) disable iff (!presetn)
		st == pid_pkg::ST_FILT ##1 st == pid_pkg::ST_IDLE);
	c_cancel: cover property (@(posedge pclk) disable iff (!presetn) pid_on && contacts.pid_cancel);
	c_int_clamped: cover property (@(posedge pclk) disable iff (!presetn) pid_on && acc == lim);
endmodule : pid_setpoint_controller

/* File: dv/sensor_model.sv */
// Purpose: contact inputs and feedback sensors on the far side of the controller
// Assumes: bench sets levels in mV and uA, converters sample once per pclk
// Notes: 12-bit converters truncate, so only multiples of 2000 mV and 4000 uA give exact codes
`timescale 1ns/1ps
module sensor_model (
	input wire logic pclk,
	input wire pid_pkg::contact_s want,
	input wire logic [13:0] ref_mv,
	input wire logic [13:0] fb_mv,
	input wire logic [14:0] fb_ua,
	output pid_pkg::contact_s contacts,
	output logic [11:0] analog_ref,
	output logic [11:0] fb_voltage,
	output logic [11:0] fb_current
);
	always @(posedge pclk) begin
		contacts <= want;
		analog_ref <= 12'(32'(ref_mv) * 32'h0000_0fff / 32'h0000_2710);
		fb_voltage <= 12'(32'(fb_mv) * 32'h0000_0fff / 32'h0000_2710);
		fb_current <= 12'(32'(fb_ua) * 32'h0000_0fff / 32'h0000_4e20);
	end
endmodule : sensor_model

/* File: dv/tb.sv */
// Purpose: self-checking bench for the pid setpoint controller
// Assumes: zero-wait apb slave, short sample period
// Notes: transient terms are caught at the first change of ref_out after a setpoint step
`timescale 1ns/1ps
module tb;
	localparam int TP = 32'h0000_00c8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, aes_enable, pid_active, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [15:0] ref_out;
	logic [13:0] ref_mv, fb_mv;
	logic [14:0] fb_ua;
	pid_pkg::contact_s want, contacts;
	logic [11:0] analog_ref, fb_voltage, fb_current;
	int n_errors, n_compared, i, n;
	logic [15:0] rst_val [13] = '{16'h0000, 16'h1770, 16'h0000, 16'h0000, 16'h0000, 16'h0258,
		16'h0064, 16'h000a, 16'h0064, 16'h0000, 16'h0000, 16'h0064, 16'h0000};
	logic [2:0] sel_in [6] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b111};
	logic [15:0] sel_out [6] = '{16'h03e8, 16'h07d0, 16'h0bb8, 16'h0fa0, 16'h1388, 16'h1388};

	pid_setpoint_controller #(.TICK_PERIOD(TP)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .contacts(contacts),
		.analog_ref(analog_ref), .fb_voltage(fb_voltage), .fb_current(fb_current),
		.ref_out(ref_out), .aes_enable(aes_enable), .pid_active(pid_active));
	sensor_model sensors (.pclk(pclk), .want(want), .ref_mv(ref_mv), .fb_mv(fb_mv),
		.fb_ua(fb_ua), .contacts(contacts), .analog_ref(analog_ref),
		.fb_voltage(fb_voltage), .fb_current(fb_current));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h00_0000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 32'h0000_0032);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc

	// bounded wait for ref_out to leave a known value; it then stands until the next tick
	task automatic wait_change(input logic [15:0] old);
		n = 0;
		while (ref_out === old && n < 32'h0000_0190) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_change

	task automatic print_verdict;
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	initial begin
		#(TP * 32'h0000_00c8);
		n_errors++;
		print_verdict();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ref_mv, fb_mv, fb_ua, want} = '0;
		cyc(5);
		presetn <= 1'b1;
		cyc(2);
		chk("pid_active", 32'h0, 32'(pid_active));
		chk("aes_enable", 32'h0, 32'(aes_enable));
		chk("pready", 32'h1, 32'(pready));
		for (i = 0; i < 13; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", 32'(rst_val[i]), rd);
		end
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped err", 32'h1, 32'(err));
		apb(1'b0, 8'h02, 32'h0);
		chk("misaligned err", 32'h1, 32'(err));
		// ordinary cases: stored setpoints chosen by jog and step contacts
		apb(1'b1, 8'h00, 32'h0000_1000);
		for (i = 0; i < 5; i++) apb(1'b1, 8'(4 + i * 4), 32'h0000_03e8 * (i + 1));
		for (i = 0; i < 6; i++) begin
			want <= pid_pkg::contact_s'({sel_in[i], 2'b00});
			cyc(5);
			chk("ref_out select", 32'(sel_out[i]), 32'(ref_out));
		end
		want <= '0;
		apb(1'b1, 8'h00, 32'h0000_0000);
		ref_mv <= 14'h2710;
		cyc(5);
		chk("ref_out analog", 32'h0000_9c40, 32'(ref_out));
		apb(1'b1, 8'h08, 32'h0000_c350);
		apb(1'b0, 8'h08, 32'h0);
		chk("clamp hz", 32'h0000_9c40, rd);
		apb(1'b1, 8'h00, 32'h0000_5000);
		apb(1'b1, 8'h08, 32'h0000_c350);
		apb(1'b0, 8'h08, 32'h0);
		chk("clamp percent", 32'h0000_2710, rd);
		// mode code alone turns on energy saving but not the pid path
		apb(1'b1, 8'h00, 32'h0000_1002);
		cyc(3);
		chk("aes_enable", 32'h1, 32'(aes_enable));
		chk("pid_active", 32'h0, 32'(pid_active));
		// dev = 6000 - 40000 * 0.10 = 2000, P = 2.0 * 2000, bias 1 % = 400
		apb(1'b1, 8'h04, 32'h0000_1770);
		apb(1'b1, 8'h18, 32'h0000_000a);
		apb(1'b1, 8'h1c, 32'h0000_0014);
		apb(1'b1, 8'h20, 32'h0000_0000);
		apb(1'b1, 8'h28, 32'h0000_0001);
		fb_mv <= 14'h2710;
		apb(1'b1, 8'h00, 32'h0000_1092);
		cyc(TP * 3);
		chk("ref_out pid", 32'h0000_1130, 32'(ref_out));
		apb(1'b0, 8'h34, 32'h0);
		chk("status", 32'h0003_1130, rd);
		fb_ua <= 15'h0fa0;
		apb(1'b1, 8'h00, 32'h0000_3092);
		cyc(TP * 3);
		chk("ref_out current", 32'h0000_3070, 32'(ref_out));
		want <= pid_pkg::contact_s'(5'b00001);
		cyc(5);
		chk("ref_out cancel", 32'h0000_1770, 32'(ref_out));
		// integral grows 6000 * 7 / 100 each tick, then the bound cuts it to 400
		want <= pid_pkg::contact_s'(5'b00010);
		apb(1'b1, 8'h28, 32'h0000_0000);
		apb(1'b1, 8'h20, 32'h0000_0001);
		want <= '0;
		cyc(TP * 3);
		apb(1'b0, 8'h38, 32'h0);
		chk("acc step", 32'h0, rd % 32'h0000_01a4);
		chk("acc grew", 32'h1, 32'(rd != 32'h0));
		apb(1'b1, 8'h2c, 32'h0000_0001);
		apb(1'b0, 8'h38, 32'h0);
		chk("acc bound", 32'h0000_0190, rd);
		want <= pid_pkg::contact_s'(5'b00010);
		cyc(TP);
		apb(1'b0, 8'h38, 32'h0);
		chk("acc reset", 32'h0, rd);
		// full-scale current feedback, derivative kick on a step down, then the lag's first step
		fb_ua <= 15'h4e20;
		apb(1'b1, 8'h20, 32'h0000_0000);
		apb(1'b1, 8'h1c, 32'h0000_000a);
		apb(1'b1, 8'h24, 32'h0000_0007);
		apb(1'b1, 8'h04, 32'h0000_1450);
		cyc(TP * 3);
		chk("ref_out steady", 32'h0000_04b0, 32'(ref_out));
		apb(1'b1, 8'h04, 32'h0000_13ec);
		wait_change(16'h04b0);
		chk("ref_out derivative", 32'h0000_0064, 32'(ref_out));
		cyc(TP * 2);
		chk("ref_out settled", 32'h0000_044c, 32'(ref_out));
		apb(1'b1, 8'h24, 32'h0000_0000);
		apb(1'b1, 8'h30, 32'h0000_0001);
		apb(1'b1, 8'h04, 32'h0000_17d4);
		wait_change(16'h044c);
		chk("ref_out lag", 32'h0000_0492, 32'(ref_out));
		want <= '0;
		apb(1'b1, 8'h00, 32'h0000_1000);
		cyc(5);
		chk("pid off", 32'h0, 32'(pid_active));
		chk("ref_out off", 32'h0000_17d4, 32'(ref_out));
		print_verdict();
	end
endmodule : tb
